// >>> rtl/i2c_channel_timing_control_map.svh
// Register map, field positions, reset values and timing counts
`ifndef I2C_CHANNEL_TIMING_CONTROL_MAP_SVH
`define I2C_CHANNEL_TIMING_CONTROL_MAP_SVH

`define ADDR_FWD_FILTER_CTRL    8'h17
`define ADDR_MASTER_HIGH_TIME   8'h18
`define ADDR_MASTER_LOW_TIME    8'h19
`define ADDR_CHANNEL_STATUS     8'h30

`define RST_FWD_FILTER_CTRL     8'h1E
`define RST_MASTER_HIGH_TIME    8'h7F
`define RST_MASTER_LOW_TIME     8'h7F

`define FLD_PASS_ALL            7
`define FLD_HOLD_MSB            6
`define FLD_HOLD_LSB            4
`define FLD_FILT_MSB            3
`define FLD_FILT_LSB            0

`define CLK_PERIOD_PS           10000
`define SCL_UNIT_TENTH_PS       380952
`define SCL_EXTRA_UNITS         5
`define HOLD_STEP_NS            40
`define FILT_STEP_PS            5000

`define SCL_UNIT_CYC  ((`SCL_UNIT_TENTH_PS + `CLK_PERIOD_PS * 10 - 1) / (`CLK_PERIOD_PS * 10))
`define HOLD_STEP_CYC ((`HOLD_STEP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define HOLD_TAPS     (7 * `HOLD_STEP_CYC)

`endif

// >>> rtl/i2c_channel_timing_pkg.sv
// Types shared by the channel timing and forwarding logic
package i2c_channel_timing_pkg;

	typedef enum logic [1:0] {
		MST_IDLE,
		MST_LOW,
		MST_HIGH
	} master_state_t;

	typedef enum logic [1:0] {
		SLV_IDLE,
		SLV_STRETCH,
		SLV_SETUP,
		SLV_DRIVE
	} slave_state_t;

	// Settings as applied to the bus
	typedef struct packed {
		logic [2:0] hold;
		logic [3:0] filt;
	} line_cfg_t;

endpackage : i2c_channel_timing_pkg

// >>> rtl/i2c_channel_timing_control.sv
// Local I2C port timing, glitch filter, SDA hold and forwarding decision
`timescale 1ns/100ps
`include "i2c_channel_timing_control_map.svh"

module i2c_channel_timing_control (
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic [7:0]       reg_addr_i,
	input  wire logic [7:0]       reg_wdata_i,
	input  wire logic             reg_wr_i,
	input  wire logic             reg_rd_i,
	output logic      [7:0]       reg_rdata_o,
	input  wire logic             second_port_select_i,
	input  wire logic [6:0]       own_addr_i,
	input  wire logic [1:0][6:0]  remote_deser_addr_i,
	input  wire logic [1:0][6:0]  remote_slave_addr_i,
	output logic      [1:0]       fwd_o,
	output logic      [6:0]       rx_addr_o,
	output logic                  bus_busy_o,
	input  wire logic             master_en_i,
	input  wire logic             slave_stretch_i,
	input  wire logic             slave_data_ready_i,
	input  wire logic             slave_sda_bit_i,
	input  wire logic             scl_i,
	output logic                  scl_o,
	output logic                  scl_oe_o,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	output logic                  sda_hold_o
);

	localparam int UNIT_CYC = `SCL_UNIT_CYC;
	localparam int TAPS     = `HOLD_TAPS;
	// Reset image of the control register; a bare literal cannot be bit-selected
	localparam logic [7:0] RST_CTRL = `RST_FWD_FILTER_CTRL;

	typedef struct packed {
		logic [1:0]                          scl_sync;
		logic [1:0]                          sda_sync;
		logic                                scl_f;
		logic                                sda_f;
		logic [3:0]                          scl_cnt;
		logic [3:0]                          sda_cnt;
		logic [TAPS-1:0]                     sda_dly;
		logic                                scl_prev;
		logic                                sda_prev;
		logic                                busy;
		logic [3:0]                          bit_cnt;
		logic [7:0]                          shift;
		logic [1:0]                          fwd;
		logic [6:0]                          addr;
		logic [1:0]                          pass_all;
		logic [2:0]                          hold_sw;
		logic [3:0]                          filt_sw;
		i2c_channel_timing_pkg::line_cfg_t   act;
		logic [7:0]                          high_time;
		logic [7:0]                          low_time;
		i2c_channel_timing_pkg::master_state_t mst;
		i2c_channel_timing_pkg::slave_state_t  slv;
		logic [2:0]                          tick_cnt;
		logic [8:0]                          unit_cnt;
		logic [2:0]                          sdiv_cnt;
		logic [8:0]                          sunit_cnt;
		logic                                mst_low;
		logic                                slv_low;
		logic                                sda_drive;
		logic [7:0]                          rdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;
	logic [1:0] rst_sync_r;
	logic       rst_n;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Filter length in cycles: a least time, so it rounds up
	function automatic logic [3:0] filt_cycles(input logic [3:0] depth);
		int c;
		c = (int'(depth) * `FILT_STEP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
		return c[3:0];
	endfunction : filt_cycles

	logic sda_held;
	logic scl_rise;
	logic start_ev;
	logic stop_ev;

	// Delayed SDA tap chosen by the applied hold setting
	always_comb begin
		if (st_r.act.hold == 3'h0) begin
			sda_held = st_r.sda_f;
		end else begin
			sda_held = st_r.sda_dly[int'(st_r.act.hold) * `HOLD_STEP_CYC - 1];
		end
	end

	assign scl_rise = st_r.scl_f && !st_r.scl_prev;
	assign start_ev = st_r.scl_f && st_r.scl_prev && st_r.sda_prev && !sda_held;
	assign stop_ev  = st_r.scl_f && st_r.scl_prev && !st_r.sda_prev && sda_held;

	// Next-state logic for the whole block
	always_comb begin
		logic [7:0] addr_byte;
		logic [8:0] limit;
		logic       sel;
		addr_byte = 8'h00;
		limit     = 9'h000;
		sel       = second_port_select_i;
		st_nxt    = st_r;

		// Pin synchronisers; first stage only feeds the second
		st_nxt.scl_sync = {st_r.scl_sync[0], scl_i};
		st_nxt.sda_sync = {st_r.sda_sync[0], sda_i};

		// Glitch filter: follow input only after it differs long enough
		if (st_r.scl_sync[1] == st_r.scl_f) begin
			st_nxt.scl_cnt = 4'h0;
		end else if (st_r.scl_cnt >= filt_cycles(st_r.act.filt)) begin
			st_nxt.scl_f   = st_r.scl_sync[1];
			st_nxt.scl_cnt = 4'h0;
		end else begin
			st_nxt.scl_cnt = st_r.scl_cnt + 4'h1;
		end
		if (st_r.sda_sync[1] == st_r.sda_f) begin
			st_nxt.sda_cnt = 4'h0;
		end else if (st_r.sda_cnt >= filt_cycles(st_r.act.filt)) begin
			st_nxt.sda_f   = st_r.sda_sync[1];
			st_nxt.sda_cnt = 4'h0;
		end else begin
			st_nxt.sda_cnt = st_r.sda_cnt + 4'h1;
		end

		// SDA delay line, one cycle per stage
		st_nxt.sda_dly  = {st_r.sda_dly[TAPS-2:0], st_r.sda_f};
		st_nxt.scl_prev = st_r.scl_f;
		st_nxt.sda_prev = sda_held;

		// Bus activity and address capture
		if (start_ev) begin
			st_nxt.busy    = 1'b1;
			st_nxt.bit_cnt = 4'h0;
			st_nxt.fwd     = 2'h0;
		end else if (stop_ev) begin
			st_nxt.busy    = 1'b0;
			st_nxt.fwd     = 2'h0;
		end else if (st_r.busy && scl_rise && st_r.bit_cnt < 4'h8) begin
			st_nxt.shift   = {st_r.shift[6:0], sda_held};
			st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
			if (st_r.bit_cnt == 4'h6) begin
				addr_byte   = {st_r.shift[6:0], sda_held};
				st_nxt.addr = addr_byte[6:0];
				for (int p = 0; p < 2; p++) begin
					if (st_r.pass_all[p]) begin
						st_nxt.fwd[p] = addr_byte[6:0] != own_addr_i;
					end else begin
						st_nxt.fwd[p] = (addr_byte[6:0] == remote_deser_addr_i[p]) ||
						                (addr_byte[6:0] == remote_slave_addr_i[p]);
					end
				end
			end
		end

		// Software copy moves to the bus only between transactions
		if (!st_r.busy && !start_ev) begin
			st_nxt.act.hold = st_r.hold_sw;
			st_nxt.act.filt = st_r.filt_sw;
		end

		// Register writes
		if (reg_wr_i) begin
			if (reg_addr_i == `ADDR_FWD_FILTER_CTRL) begin
				st_nxt.pass_all[sel] = reg_wdata_i[`FLD_PASS_ALL];
				st_nxt.hold_sw = reg_wdata_i[`FLD_HOLD_MSB:`FLD_HOLD_LSB];
				st_nxt.filt_sw = reg_wdata_i[`FLD_FILT_MSB:`FLD_FILT_LSB];
			end else if (reg_addr_i == `ADDR_MASTER_HIGH_TIME) begin
				st_nxt.high_time = reg_wdata_i;
			end else if (reg_addr_i == `ADDR_MASTER_LOW_TIME) begin
				st_nxt.low_time = reg_wdata_i;
			end
		end

		// Register reads, data stand one cycle later; unmapped reads zero
		st_nxt.rdata = 8'h00;
		if (reg_rd_i) begin
			if (reg_addr_i == `ADDR_FWD_FILTER_CTRL) begin
				st_nxt.rdata = {st_r.pass_all[sel], st_r.hold_sw, st_r.filt_sw};
			end else if (reg_addr_i == `ADDR_MASTER_HIGH_TIME) begin
				st_nxt.rdata = st_r.high_time;
			end else if (reg_addr_i == `ADDR_MASTER_LOW_TIME) begin
				st_nxt.rdata = st_r.low_time;
			end else if (reg_addr_i == `ADDR_CHANNEL_STATUS) begin
				st_nxt.rdata = {st_r.busy, st_r.fwd, st_r.mst != i2c_channel_timing_pkg::MST_IDLE,
				                st_r.slv != i2c_channel_timing_pkg::SLV_IDLE,
				                st_r.scl_f, st_r.sda_f, sda_held};
			end
		end

		// Master clock: unit tick divider then count value plus five units
		if (st_r.tick_cnt == 3'(UNIT_CYC - 1)) begin
			st_nxt.tick_cnt = 3'h0;
		end else begin
			st_nxt.tick_cnt = st_r.tick_cnt + 3'h1;
		end
		case (st_r.mst)
			i2c_channel_timing_pkg::MST_IDLE: begin
				st_nxt.mst_low = 1'b0;
				if (master_en_i) begin
					st_nxt.mst      = i2c_channel_timing_pkg::MST_LOW;
					st_nxt.mst_low  = 1'b1;
					st_nxt.tick_cnt = 3'h0;
					st_nxt.unit_cnt = 9'h000;
				end
			end
			i2c_channel_timing_pkg::MST_LOW: begin
				limit = {1'b0, st_r.low_time} + 9'(`SCL_EXTRA_UNITS);
				if (st_r.tick_cnt == 3'(UNIT_CYC - 1)) begin
					st_nxt.unit_cnt = st_r.unit_cnt + 9'h001;
					if (st_r.unit_cnt + 9'h001 >= limit) begin
						st_nxt.mst      = i2c_channel_timing_pkg::MST_HIGH;
						st_nxt.mst_low  = 1'b0;
						st_nxt.unit_cnt = 9'h000;
					end
				end
			end
			i2c_channel_timing_pkg::MST_HIGH: begin
				limit = {1'b0, st_r.high_time} + 9'(`SCL_EXTRA_UNITS);
				if (!st_r.scl_f) begin
					// Stretched by a slave: high time starts when the line is seen high
					st_nxt.tick_cnt = 3'h0;
					st_nxt.unit_cnt = 9'h000;
				end else if (st_r.tick_cnt == 3'(UNIT_CYC - 1)) begin
					st_nxt.unit_cnt = st_r.unit_cnt + 9'h001;
					if (st_r.unit_cnt + 9'h001 >= limit) begin
						st_nxt.unit_cnt = 9'h000;
						if (master_en_i) begin
							st_nxt.mst     = i2c_channel_timing_pkg::MST_LOW;
							st_nxt.mst_low = 1'b1;
						end else begin
							st_nxt.mst = i2c_channel_timing_pkg::MST_IDLE;
						end
					end
				end
			end
			default: begin
				st_nxt.mst = i2c_channel_timing_pkg::MST_IDLE;
			end
		endcase

		// Slave stretch with SDA setup before release
		if (st_r.sdiv_cnt == 3'(UNIT_CYC - 1)) begin
			st_nxt.sdiv_cnt = 3'h0;
		end else begin
			st_nxt.sdiv_cnt = st_r.sdiv_cnt + 3'h1;
		end
		case (st_r.slv)
			i2c_channel_timing_pkg::SLV_IDLE: begin
				st_nxt.slv_low   = 1'b0;
				st_nxt.sda_drive = 1'b0;
				if (slave_stretch_i) begin
					st_nxt.slv     = i2c_channel_timing_pkg::SLV_STRETCH;
					st_nxt.slv_low = 1'b1;
				end
			end
			i2c_channel_timing_pkg::SLV_STRETCH: begin
				if (slave_data_ready_i) begin
					st_nxt.slv       = i2c_channel_timing_pkg::SLV_SETUP;
					st_nxt.sda_drive = !slave_sda_bit_i;
					st_nxt.sdiv_cnt  = 3'h0;
					st_nxt.sunit_cnt = 9'h000;
				end else if (!slave_stretch_i) begin
					st_nxt.slv     = i2c_channel_timing_pkg::SLV_IDLE;
					st_nxt.slv_low = 1'b0;
				end
			end
			i2c_channel_timing_pkg::SLV_SETUP: begin
				limit = {1'b0, st_r.low_time} + 9'(`SCL_EXTRA_UNITS);
				if (st_r.sdiv_cnt == 3'(UNIT_CYC - 1)) begin
					st_nxt.sunit_cnt = st_r.sunit_cnt + 9'h001;
					if (st_r.sunit_cnt + 9'h001 >= limit) begin
						st_nxt.slv     = i2c_channel_timing_pkg::SLV_DRIVE;
						st_nxt.slv_low = 1'b0;
					end
				end
			end
			i2c_channel_timing_pkg::SLV_DRIVE: begin
				// Data held until the slave side drops its request
				if (!slave_stretch_i) begin
					st_nxt.slv       = i2c_channel_timing_pkg::SLV_IDLE;
					st_nxt.sda_drive = 1'b0;
				end
			end
			default: begin
				st_nxt.slv = i2c_channel_timing_pkg::SLV_IDLE;
			end
		endcase
	end

	// Single state register; reset takes constants only
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r           <= '0;
			st_r.scl_sync  <= 2'h3;
			st_r.sda_sync  <= 2'h3;
			st_r.scl_f     <= 1'b1;
			st_r.sda_f     <= 1'b1;
			st_r.scl_prev  <= 1'b1;
			st_r.sda_prev  <= 1'b1;
			st_r.sda_dly   <= '1;
			st_r.pass_all  <= {2{RST_CTRL[`FLD_PASS_ALL]}};
			st_r.hold_sw   <= RST_CTRL[`FLD_HOLD_MSB:`FLD_HOLD_LSB];
			st_r.filt_sw   <= RST_CTRL[`FLD_FILT_MSB:`FLD_FILT_LSB];
			st_r.act.hold  <= RST_CTRL[`FLD_HOLD_MSB:`FLD_HOLD_LSB];
			st_r.act.filt  <= RST_CTRL[`FLD_FILT_MSB:`FLD_FILT_LSB];
			st_r.high_time <= `RST_MASTER_HIGH_TIME;
			st_r.low_time  <= `RST_MASTER_LOW_TIME;
			st_r.mst       <= i2c_channel_timing_pkg::MST_IDLE;
			st_r.slv       <= i2c_channel_timing_pkg::SLV_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs; open-drain lines only ever pull low
	assign reg_rdata_o = st_r.rdata;
	assign fwd_o       = st_r.fwd;
	assign rx_addr_o   = st_r.addr;
	assign bus_busy_o  = st_r.busy;
	assign scl_o       = 1'b0;
	assign sda_o       = 1'b0;
	assign scl_oe_o    = st_r.mst_low | st_r.slv_low;
	assign sda_oe_o    = st_r.sda_drive;
	assign sda_hold_o  = sda_held;

endmodule : i2c_channel_timing_control

// >>> tb/i2c_timing_checker_assertions.sv
// Port-level checker for the I2C timing and forwarding control block
`timescale 1ns/100ps
module i2c_timing_checker (
	input wire logic            clock_i,
	input wire logic            arst_n_i,
	input wire logic [7:0]      reg_addr_i,
	input wire logic [7:0]      reg_wdata_i,
	input wire logic            reg_wr_i,
	input wire logic            reg_rd_i,
	input wire logic [7:0]      reg_rdata_o,
	input wire logic            second_port_select_i,
	input wire logic [6:0]      own_addr_i,
	input wire logic [1:0][6:0] remote_deser_addr_i,
	input wire logic [1:0][6:0] remote_slave_addr_i,
	input wire logic [1:0]      fwd_o,
	input wire logic [6:0]      rx_addr_o,
	input wire logic            master_en_i,
	input wire logic            slave_data_ready_i,
	input wire logic            scl_oe_o
);
	logic [7:0]  hi_r;
	logic [7:0]  lo_r;
	logic [1:0]  pa_r;
	logic        sel_r;
	logic [11:0] on_r;
	logic [11:0] off_r;
	logic [11:0] rdy_r;
	logic [11:0] lo_len;
	logic [11:0] hi_len;
	// Widths in cycles: four cycles per unit, five extra units
	assign lo_len = (12'(lo_r) + 12'h005) << 2;
	assign hi_len = (12'(hi_r) + 12'h005) << 2;
	// Shadow of written settings; idle and ready counters saturate so they never wrap
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hi_r <= 8'h7F;
			lo_r <= 8'h7F;
			pa_r <= 2'h0;
			sel_r <= 1'b0;
			on_r <= 12'h000;
			off_r <= 12'hFFF;
			rdy_r <= 12'h000;
		end else begin
			if (reg_wr_i && reg_addr_i == 8'h18) hi_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h19) lo_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == 8'h17) pa_r[second_port_select_i] <= reg_wdata_i[7];
			sel_r <= second_port_select_i;
			on_r <= scl_oe_o ? on_r + 12'h001 : 12'h000;
			off_r <= (scl_oe_o) ? 12'h000 : ((&off_r) ? off_r : off_r + 12'h001);
			rdy_r <= slave_data_ready_i ? 12'h000 : ((&rdy_r) ? rdy_r : rdy_r + 12'h001);
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	a_low_width: assert property (
		$fell(scl_oe_o) && master_en_i |-> on_r >= lo_len)
		else $error("master low phase too short");
	a_high_width: assert property (
		$rose(scl_oe_o) && master_en_i |-> off_r >= hi_len)
		else $error("master high phase too short");
	a_setup_time: assert property (
		$fell(scl_oe_o) && !master_en_i |-> rdy_r >= lo_len)
		else $error("stretch released before setup interval");
	a_high_read: assert property (
		reg_rd_i && reg_addr_i == 8'h18 |=> reg_rdata_o == hi_r)
		else $error("high time readback wrong");
	a_low_read: assert property (
		reg_rd_i && reg_addr_i == 8'h19 |=> reg_rdata_o == lo_r)
		else $error("low time readback wrong");
	a_pass_read: assert property (
		reg_rd_i && reg_addr_i == 8'h17 |=> reg_rdata_o[7] == pa_r[sel_r])
		else $error("pass-all readback of selected port wrong");
	a_fwd_port0: assert property (
		$rose(fwd_o[0]) && !pa_r[0] |->
		rx_addr_o == remote_deser_addr_i[0] || rx_addr_o == remote_slave_addr_i[0])
		else $error("port 0 forwarded an unmatched address");
	a_fwd_port1: assert property (
		$rose(fwd_o[1]) && !pa_r[1] |->
		rx_addr_o == remote_deser_addr_i[1] || rx_addr_o == remote_slave_addr_i[1])
		else $error("port 1 forwarded an unmatched address");
	a_fwd_not_own: assert property (
		$rose(fwd_o[0]) || $rose(fwd_o[1]) |-> rx_addr_o != own_addr_i)
		else $error("own address was forwarded");
	c_master_cycle: cover property ($fell(scl_oe_o) && master_en_i);
	c_slave_release: cover property ($fell(scl_oe_o) && !master_en_i);
	c_fwd_port1: cover property ($rose(fwd_o[1]));
endmodule : i2c_timing_checker

bind i2c_channel_timing_control i2c_timing_checker chk (.*);

// >>> tb/local_i2c_party.sv
// Local I2C host model: pulled-up open-drain wires and bus phase tasks
`timescale 1ns/100ps
module local_i2c_party (
	input  wire logic clock_i,
	input  wire logic scl_oe_i,
	input  wire logic sda_oe_i,
	output logic      scl_line_o,
	output logic      sda_line_o
);
	logic scl_pull_r = 1'b0;
	logic sda_pull_r = 1'b0;
	// Pull-ups win unless either party pulls low
	assign scl_line_o = !(scl_pull_r || scl_oe_i);
	assign sda_line_o = !(sda_pull_r || sda_oe_i);
	// One bus phase; n sets how slowly the host moves on
	task automatic step(input logic c, input logic d, input int n);
		@(posedge clock_i);
		scl_pull_r <= !c;
		sda_pull_r <= !d;
		repeat (n) @(posedge clock_i);
	endtask : step
	// Start, then seven address bits, most significant first
	task automatic send_addr(input logic [6:0] a);
		step(1'b1, 1'b0, 20);
		for (int i = 6; i >= 0; i--) begin
			step(1'b0, a[i], 20);
			step(1'b1, a[i], 20);
		end
		step(1'b0, a[0], 20);
	endtask : send_addr
	task automatic stop();
		step(1'b0, 1'b0, 20);
		step(1'b1, 1'b0, 20);
		step(1'b1, 1'b1, 20);
	endtask : stop
endmodule : local_i2c_party

// >>> tb/test_i2c_channel_timing_control.sv
// Self-checking bench for I2C timing and forwarding control
`timescale 1ns/100ps
module test_i2c_channel_timing_control;
	typedef struct {
		logic       pa0;
		logic       pa1;
		logic [6:0] adr;
		logic [1:0] fwd;
	} row_t;
	logic            clock_i;
	logic            arst_n_i;
	logic [7:0]      reg_addr_i;
	logic [7:0]      reg_wdata_i;
	logic            reg_wr_i;
	logic            reg_rd_i;
	logic [7:0]      reg_rdata_o;
	logic            second_port_select_i;
	logic [6:0]      own_addr_i;
	logic [1:0][6:0] remote_deser_addr_i;
	logic [1:0][6:0] remote_slave_addr_i;
	logic [1:0]      fwd_o;
	logic [6:0]      rx_addr_o;
	logic            bus_busy_o;
	logic            master_en_i;
	logic            slave_stretch_i;
	logic            slave_data_ready_i;
	logic            slave_sda_bit_i;
	logic            scl_i;
	logic            scl_o;
	logic            scl_oe_o;
	logic            sda_i;
	logic            sda_o;
	logic            sda_oe_o;
	logic            sda_hold_o;
	int              error_cnt = 0;
	int              check_count = 0;
	int              n;
	int              m;
	logic [7:0]      rv;
	// Port 0 answers 0x2A/0x50, port 1 0x2C/0x51, own address 0x0C
	row_t rows [7] = '{'{1'b0, 1'b0, 7'h2A, 2'h1}, '{1'b0, 1'b0, 7'h51, 2'h2},
		'{1'b0, 1'b0, 7'h33, 2'h0}, '{1'b1, 1'b0, 7'h33, 2'h1}, '{1'b0, 1'b1, 7'h33, 2'h2},
		'{1'b1, 1'b1, 7'h0C, 2'h0}, '{1'b1, 1'b1, 7'h50, 2'h3}};

	i2c_channel_timing_control DUT (.*);
	local_i2c_party p (.clock_i(clock_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
		.scl_line_o(scl_i), .sda_line_o(sda_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		second_port_select_i <= s;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
		@(posedge clock_i);
		second_port_select_i <= s;
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, e);
	endtask : rd
	// Counts cycles while the clock pull-down stays at v, bounded
	task automatic run_len(input logic v);
		n = 0;
		while (scl_oe_o === v && n < 4000) begin
			@(posedge clock_i);
			#1 n++;
		end
	endtask : run_len
	// Latency from SDA pin change to the held copy, SCL kept low
	task automatic hold_lat();
		p.step(1'b0, 1'b1, 40);
		p.step(1'b0, 1'b0, 0);
		#1 m = 0;
		while (sda_hold_o !== 1'b0 && m < 200) begin
			@(posedge clock_i);
			#1 m++;
		end
		p.step(1'b0, 1'b1, 40);
		p.step(1'b1, 1'b1, 40);
	endtask : hold_lat
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Whole run is under ten thousand cycles
	initial begin
		#200000;
		error_cnt++;
		$display("wrong value at %0t: run did not finish", $time);
		wrap_up();
	end

	initial begin
		{arst_n_i, reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
		{second_port_select_i, master_en_i, slave_stretch_i, slave_data_ready_i} = '0;
		slave_sda_bit_i = 1'b1;
		own_addr_i = 7'h0C;
		remote_deser_addr_i = {7'h2C, 7'h2A};
		remote_slave_addr_i = {7'h51, 7'h50};
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		// Forwarding policy per port, one address phase each
		foreach (rows[i]) begin
			wr(1'b1, 8'h17, {rows[i].pa1, 7'h1E});
			wr(1'b0, 8'h17, {rows[i].pa0, 7'h1E});
			p.send_addr(rows[i].adr);
			check(bus_busy_o, 1'b1);
			check(fwd_o, rows[i].fwd);
			check(rx_addr_o, rows[i].adr);
			p.stop();
			check(fwd_o, 2'h0);
			$display("forward row %0d done", i);
		end
		// Filter depth zero written mid-transfer must wait for the stop
		p.send_addr(7'h50);
		wr(1'b0, 8'h17, 8'h10);
		p.step(1'b0, 1'b1, 20);
		p.step(1'b1, 1'b1, 20);
		p.step(1'b1, 1'b0, 2);
		p.step(1'b1, 1'b1, 30);
		check(bus_busy_o, 1'b1);
		check(fwd_o, 2'h3);
		p.stop();
		wr(1'b0, 8'h17, 8'h1E);
		$display("late setting test done");
		// Three-cycle SDA dip with SCL high must not look like a start
		p.step(1'b1, 1'b0, 2);
		p.step(1'b1, 1'b1, 30);
		check(bus_busy_o, 1'b0);
		$display("glitch test done");
		// Two extra hold steps add eight cycles of SDA delay
		hold_lat();
		rv = 8'(m);
		wr(1'b0, 8'h17, 8'h3E);
		hold_lat();
		check(12'(m) - 12'(rv), 12'h008);
		$display("hold test done");
		// Master clock: low 2 and high 3 give 28 and at least 32 cycles
		wr(1'b0, 8'h19, 8'h02);
		wr(1'b0, 8'h18, 8'h03);
		@(posedge clock_i);
		master_en_i <= 1'b1;
		#1 run_len(1'b0);
		run_len(1'b1);
		check(12'(n), 12'h01C);
		run_len(1'b0);
		check(n >= 32, 1'b1);
		@(posedge clock_i);
		master_en_i <= 1'b0;
		repeat (300) @(posedge clock_i);
		$display("master test done");
		// Slave stretch: data driven 28 cycles before SCL is let go
		slave_stretch_i <= 1'b1;
		repeat (10) @(posedge clock_i);
		check(scl_oe_o, 1'b1);
		slave_sda_bit_i <= 1'b0;
		slave_data_ready_i <= 1'b1;
		@(posedge clock_i);
		slave_data_ready_i <= 1'b0;
		#1 check(sda_oe_o, 1'b1);
		run_len(1'b1);
		check(12'(n), 12'h01C);
		slave_stretch_i <= 1'b0;
		repeat (50) @(posedge clock_i);
		$display("slave test done");
		// Second reset mid-run, then defaults, unmapped place and port select
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd(1'b0, 8'h17, 8'h1E);
		rd(1'b0, 8'h18, 8'h7F);
		rd(1'b0, 8'h19, 8'h7F);
		rd(1'b0, 8'h20, 8'h00);
		rd(1'b0, 8'h30, 8'h07);
		check(scl_o, 1'b0);
		check(sda_o, 1'b0);
		wr(1'b1, 8'h17, 8'h9E);
		rd(1'b1, 8'h17, 8'h9E);
		rd(1'b0, 8'h17, 8'h1E);
		$display("register test done");
		wrap_up();
	end
endmodule : test_i2c_channel_timing_control
